// [temp_sensor_pkg.sv]
// Constants of the two-channel temperature sensor conversion controller.
// Assumes a 10 MHz system clock and a command-byte register port fed by an SMBus framer.

package temp_sensor_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] RD_LOCAL_HB    = 8'h00;
    localparam logic [7:0] RD_REMOTE_HB   = 8'h01;
    localparam logic [7:0] RD_STATUS      = 8'h02;
    localparam logic [7:0] RD_CONFIG      = 8'h03;
    localparam logic [7:0] RD_RATE        = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH  = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW   = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW  = 8'h08;
    localparam logic [7:0] WR_CONFIG      = 8'h09;
    localparam logic [7:0] WR_RATE        = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HIGH  = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LOW   = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LOW  = 8'h0E;
    localparam logic [7:0] WR_ONE_SHOT    = 8'h0F;
    localparam logic [7:0] RD_REMOTE_LB   = 8'h10;
    localparam logic [7:0] RW_REM_HIGH_LB = 8'h13;
    localparam logic [7:0] RW_REM_LOW_LB  = 8'h14;
    localparam logic [7:0] RW_REMOTE_CRIT = 8'h19;
    localparam logic [7:0] RW_LOCAL_CRIT  = 8'h20;
    localparam logic [7:0] RD_LOCAL_LB    = 8'h22;

    // ==========================================================
    // Field positions
    localparam int CFG_ALERT_MASK  = 7;
    localparam int CFG_STANDBY     = 6;
    localparam int CFG_REMOTE_CRITICAL_FLAG_MASK  = 4;
    localparam int CFG_LOCAL_CRITICAL_FLAG_MASK  = 2;
    localparam int CFG_FAULT_QUEUE = 0;
    localparam logic [7:0] CFG_DEFINED = 8'hD5;
    localparam int ST_BUSY  = 7;
    localparam int ST_LHIGH = 6;
    localparam int ST_LLOW  = 5;
    localparam int ST_RHIGH = 4;
    localparam int ST_RLOW  = 3;
    localparam int ST_OPEN  = 2;
    localparam int ST_REMOTE_CRITICAL_FLAG = 1;
    localparam int ST_LOCAL_CRITICAL_FLAG = 0;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] CONFIG_RESET     = 8'h00;
    localparam logic [3:0] RATE_RESET       = 4'h8;
    localparam logic [3:0] RATE_MAX         = 4'h9;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'h46;
    localparam logic [7:0] LOW_LIMIT_RESET  = 8'h00;
    localparam logic [7:0] CRIT_RESET       = 8'h55;
    localparam logic [7:0] ONE_SHOT_READ    = 8'hFF;
    localparam logic [1:0] QUEUE_DEPTH      = 2'h3;

    // ==========================================================
    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int CONV_TIME_MS    = 38;
    localparam int CONV_CYCLES     = CONV_TIME_MS * (CLK_HZ / 1000);
    // Slowest rate, code 00h, is one conversion per 16 s
    localparam int SLOW_PERIOD_MS  = 16_000;
    localparam longint SLOW_CYCLES = longint'(SLOW_PERIOD_MS) * (CLK_HZ / 1000);

    typedef enum logic [1:0] {IDLE, CONVERT, COMMIT} conv_state_e;

endpackage : temp_sensor_pkg

// [temp_sensor_conversion_control.sv]
// Conversion sequencing, limit checking and register file of the sensor.
// Assumes the SMBus framer hands over decoded command-byte accesses as one-cycle
// requests on clk, and the converter front end presents samples on clk.

`timescale 1ns/10ps

module temp_sensor_conversion_control #(
    parameter int          CONV_CYCLES = temp_sensor_pkg::CONV_CYCLES,
    parameter logic [27:0] SLOW_CYCLES = 28'(temp_sensor_pkg::SLOW_CYCLES)
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        wr_req,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_req,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    input  wire logic [10:0] local_sample,
    input  wire logic [10:0] remote_sample,
    input  wire logic        diode_open,
    output logic             alert_output,
    output logic             critical_output,
    output logic             converting
);

    // ==========================================================
    // Registers
    logic [7:0]  device_configuration;
    logic [3:0]  conversion_interval;
    logic [7:0]  local_high, local_low, local_crit, remote_crit;
    logic [7:0]  remote_high_hb, remote_low_hb;
    logic [2:0]  remote_high_lb, remote_low_lb;
    logic [10:0] local_temp, remote_temp;
    logic [6:0]  flags;
    logic [1:0]  queue_count [3];
    logic [27:0] interval_count;
    logic [18:0] conv_count;
    logic        one_shot_pending;
    temp_sensor_pkg::conv_state_e state, next_state;

    // ==========================================================
    // Register port decode
    wire wr_config   = wr_req && cmd_code == temp_sensor_pkg::WR_CONFIG;
    wire wr_rate     = wr_req && cmd_code == temp_sensor_pkg::WR_RATE;
    wire wr_lhigh    = wr_req && cmd_code == temp_sensor_pkg::WR_LOCAL_HIGH;
    wire wr_llow     = wr_req && cmd_code == temp_sensor_pkg::WR_LOCAL_LOW;
    wire wr_rhigh    = wr_req && cmd_code == temp_sensor_pkg::WR_REMOTE_HIGH;
    wire wr_rlow     = wr_req && cmd_code == temp_sensor_pkg::WR_REMOTE_LOW;
    wire wr_rhigh_lb = wr_req && cmd_code == temp_sensor_pkg::RW_REM_HIGH_LB;
    wire wr_rlow_lb  = wr_req && cmd_code == temp_sensor_pkg::RW_REM_LOW_LB;
    wire wr_remote_critical_flag    = wr_req && cmd_code == temp_sensor_pkg::RW_REMOTE_CRIT;
    wire wr_local_critical_flag    = wr_req && cmd_code == temp_sensor_pkg::RW_LOCAL_CRIT;
    // Data byte of a one-shot write is not looked at
    wire wr_one_shot = wr_req && cmd_code == temp_sensor_pkg::WR_ONE_SHOT;
    wire rd_status   = rd_req && cmd_code == temp_sensor_pkg::RD_STATUS;

    wire standby     = device_configuration[temp_sensor_pkg::CFG_STANDBY];
    wire conv_done   = state == temp_sensor_pkg::CONVERT
                       && conv_count == 19'(CONV_CYCLES - 1);
    wire interval_up = interval_count == 28'h0000000;
    // Out-of-range rate codes run at the fastest defined rate
    wire [3:0] rate_code = (conversion_interval > temp_sensor_pkg::RATE_MAX)
                           ? temp_sensor_pkg::RATE_MAX : conversion_interval;
    wire [27:0] interval_period = SLOW_CYCLES >> rate_code;
    wire start_run   = !standby && interval_up;
    wire start_conv  = state == temp_sensor_pkg::IDLE && (start_run || one_shot_pending);

    // ==========================================================
    // Limit comparison, all signed against eighth-degree readings
    wire signed [10:0] loc  = local_sample;
    wire signed [10:0] rem  = remote_sample;
    wire signed [10:0] lim_lhigh = {local_high, 3'h0};
    wire signed [10:0] lim_llow  = {local_low, 3'h0};
    wire signed [10:0] lim_local_critical_flag = {local_crit, 3'h0};
    wire signed [10:0] lim_remote_critical_flag = {remote_crit, 3'h0};
    wire signed [10:0] lim_rhigh = {remote_high_hb, remote_high_lb};
    wire signed [10:0] lim_rlow  = {remote_low_hb, remote_low_lb};
    wire cmp_lhigh = loc > lim_lhigh;
    wire cmp_llow  = loc < lim_llow;
    wire cmp_local_critical_flag = loc > lim_local_critical_flag;
    wire [2:0] cmp_remote = {rem > lim_rhigh, rem < lim_rlow, rem > lim_remote_critical_flag};
    wire [1:0] queue_need = device_configuration[temp_sensor_pkg::CFG_FAULT_QUEUE]
                            ? temp_sensor_pkg::QUEUE_DEPTH : 2'h1;
    wire [2:0] remote_hit;

    // Consecutive-fault counters per remote condition, reset by an in-limit reading
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_queue
            wire [1:0] next_count = cmp_remote[g]
                ? ((queue_count[g] == temp_sensor_pkg::QUEUE_DEPTH)
                   ? queue_count[g] : queue_count[g] + 2'h1)
                : 2'h0;
            assign remote_hit[g] = next_count >= queue_need;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    queue_count[g] <= 2'h0;
                else if (conv_done)
                    queue_count[g] <= next_count;
            end
        end
    endgenerate

    // Order follows status bits 6..0: lhigh llow rhigh rlow open remote_critical_flag local_critical_flag
    wire [6:0] new_flags = {cmp_lhigh, cmp_llow, remote_hit[2], remote_hit[1],
                            diode_open, remote_hit[0], cmp_local_critical_flag};
    // Status read clears latched flags; a fresh hit in the same cycle wins
    wire [6:0] next_flags = (rd_status ? 7'h00 : flags) | (conv_done ? new_flags : 7'h00);
    wire [7:0] status_flags = {state != temp_sensor_pkg::IDLE, flags};

    // ==========================================================
    // Conversion sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            temp_sensor_pkg::IDLE:    if (start_conv) next_state = temp_sensor_pkg::CONVERT;
            temp_sensor_pkg::CONVERT: if (conv_done) next_state = temp_sensor_pkg::COMMIT;
            temp_sensor_pkg::COMMIT:  next_state = temp_sensor_pkg::IDLE;
            default:                  next_state = temp_sensor_pkg::IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= temp_sensor_pkg::IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            conv_count <= 19'h00000;
        else if (state != temp_sensor_pkg::CONVERT)
            conv_count <= 19'h00000;
        else
            conv_count <= conv_count + 19'h00001;
    end

    // Interval timer idles in standby so only one-shot conversions run there
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            interval_count <= 28'h0000000;
        else if (standby)
            interval_count <= 28'h0000000;
        else if (start_conv)
            interval_count <= interval_period - 28'h0000001;
        else if (!interval_up)
            interval_count <= interval_count - 28'h0000001;
    end

    // A one-shot written in standby is remembered until its conversion starts, so one request runs once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            one_shot_pending <= 1'b0;
        else if (wr_one_shot && standby)
            one_shot_pending <= 1'b1;
        else if (start_conv)
            one_shot_pending <= 1'b0;
    end

    // ==========================================================
    // Result and flag commit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            local_temp  <= 11'h000;
            remote_temp <= 11'h000;
        end
        else if (conv_done)
        begin
            local_temp  <= local_sample;
            remote_temp <= remote_sample;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags <= 7'h00;
        else
            flags <= next_flags;
    end

    // ==========================================================
    // Writable registers; writes accepted in any mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            device_configuration <= temp_sensor_pkg::CONFIG_RESET;
            conversion_interval  <= temp_sensor_pkg::RATE_RESET;
        end
        else
        begin
            if (wr_config)
                device_configuration <= wr_data & temp_sensor_pkg::CFG_DEFINED;
            if (wr_rate)
                conversion_interval <= wr_data[3:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            local_high     <= temp_sensor_pkg::HIGH_LIMIT_RESET;
            local_low      <= temp_sensor_pkg::LOW_LIMIT_RESET;
            remote_high_hb <= temp_sensor_pkg::HIGH_LIMIT_RESET;
            remote_low_hb  <= temp_sensor_pkg::LOW_LIMIT_RESET;
            remote_high_lb <= 3'h0;
            remote_low_lb  <= 3'h0;
            local_crit     <= temp_sensor_pkg::CRIT_RESET;
            remote_crit    <= temp_sensor_pkg::CRIT_RESET;
        end
        else
        begin
            if (wr_lhigh)    local_high     <= wr_data;
            if (wr_llow)     local_low      <= wr_data;
            if (wr_rhigh)    remote_high_hb <= wr_data;
            if (wr_rlow)     remote_low_hb  <= wr_data;
            if (wr_rhigh_lb) remote_high_lb <= wr_data[7:5];
            if (wr_rlow_lb)  remote_low_lb  <= wr_data[7:5];
            if (wr_remote_critical_flag)    remote_crit    <= wr_data;
            if (wr_local_critical_flag)    local_crit     <= wr_data;
        end
    end

    // ==========================================================
    // Read mux; unmapped codes read zero
    logic [7:0] read_mux;
    always_comb
    begin
        read_mux = 8'h00;
        unique case (cmd_code)
            temp_sensor_pkg::RD_LOCAL_HB:    read_mux = local_temp[10:3];
            temp_sensor_pkg::RD_REMOTE_HB:   read_mux = remote_temp[10:3];
            temp_sensor_pkg::RD_LOCAL_LB:    read_mux = {local_temp[2:0], 5'h00};
            temp_sensor_pkg::RD_REMOTE_LB:   read_mux = {remote_temp[2:0], 5'h00};
            temp_sensor_pkg::RD_STATUS:      read_mux = status_flags;
            temp_sensor_pkg::RD_CONFIG:      read_mux = device_configuration;
            temp_sensor_pkg::RD_RATE:        read_mux = {4'h0, conversion_interval};
            temp_sensor_pkg::RD_LOCAL_HIGH:  read_mux = local_high;
            temp_sensor_pkg::RD_LOCAL_LOW:   read_mux = local_low;
            temp_sensor_pkg::RD_REMOTE_HIGH: read_mux = remote_high_hb;
            temp_sensor_pkg::RD_REMOTE_LOW:  read_mux = remote_low_hb;
            temp_sensor_pkg::RW_REM_HIGH_LB: read_mux = {remote_high_lb, 5'h00};
            temp_sensor_pkg::RW_REM_LOW_LB:  read_mux = {remote_low_lb, 5'h00};
            temp_sensor_pkg::RW_REMOTE_CRIT: read_mux = remote_crit;
            temp_sensor_pkg::RW_LOCAL_CRIT:  read_mux = local_crit;
            temp_sensor_pkg::WR_ONE_SHOT:    read_mux = temp_sensor_pkg::ONE_SHOT_READ;
            default:                         read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_req;
            if (rd_req)
                rd_data <= read_mux;
        end
    end

    // ==========================================================
    // Outputs; open-diode and busy never raise the alert
    wire alert_cause = |{flags[6:3], flags[1:0]};
    wire crit_cause  = (flags[temp_sensor_pkg::ST_REMOTE_CRITICAL_FLAG]
                        && !device_configuration[temp_sensor_pkg::CFG_REMOTE_CRITICAL_FLAG_MASK])
                     || (flags[temp_sensor_pkg::ST_LOCAL_CRITICAL_FLAG]
                        && !device_configuration[temp_sensor_pkg::CFG_LOCAL_CRITICAL_FLAG_MASK]);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alert_output    <= 1'b0;
            critical_output <= 1'b0;
        end
        else
        begin
            alert_output <= alert_cause
                && !device_configuration[temp_sensor_pkg::CFG_ALERT_MASK];
            critical_output <= crit_cause;
        end
    end

    assign converting = status_flags[temp_sensor_pkg::ST_BUSY];

    // ==========================================================
    // Checks
    a_standby_idle: assert property (@(posedge clk) disable iff (rst)
        standby && !one_shot_pending && state == temp_sensor_pkg::IDLE
        |=> state == temp_sensor_pkg::IDLE)
        else $error("conversion started in standby without one-shot");

    a_run_restart: assert property (@(posedge clk) disable iff (rst)
        !standby && interval_up && state == temp_sensor_pkg::IDLE
        && !wr_config |=> state == temp_sensor_pkg::CONVERT)
        else $error("free run did not start conversion");

    a_busy_span: assert property (@(posedge clk) disable iff (rst)
        $rose(state == temp_sensor_pkg::CONVERT)
        |-> converting [*8])
        else $error("busy dropped early");

    a_result_store: assert property (@(posedge clk) disable iff (rst)
        conv_done |=> local_temp == $past(local_sample)
                      && remote_temp == $past(remote_sample))
        else $error("results not stored at conversion end");

    a_alert_mask: assert property (@(posedge clk) disable iff (rst)
        device_configuration[temp_sensor_pkg::CFG_ALERT_MASK] |=> !alert_output)
        else $error("alert not masked");

    a_crit_mask: assert property (@(posedge clk) disable iff (rst)
        device_configuration[temp_sensor_pkg::CFG_REMOTE_CRITICAL_FLAG_MASK]
        && device_configuration[temp_sensor_pkg::CFG_LOCAL_CRITICAL_FLAG_MASK] |=> !critical_output)
        else $error("critical output not masked");

    a_queue_single: assert property (@(posedge clk) disable iff (rst)
        conv_done && !device_configuration[temp_sensor_pkg::CFG_FAULT_QUEUE]
        && cmp_remote[2] |=> flags[temp_sensor_pkg::ST_RHIGH])
        else $error("remote high not flagged on single fault");

    a_config_read: assert property (@(posedge clk) disable iff (rst)
        rd_req && cmd_code == temp_sensor_pkg::RD_CONFIG
        |=> rd_valid && rd_data == $past(device_configuration))
        else $error("configuration read wrong");

    a_low_byte: assert property (@(posedge clk) disable iff (rst)
        rd_req && cmd_code == temp_sensor_pkg::RD_REMOTE_LB |=> rd_data[4:0] == 5'h00)
        else $error("remote low byte low bits not zero");

    a_undef_zero: assert property (@(posedge clk) disable iff (rst)
        (device_configuration & ~temp_sensor_pkg::CFG_DEFINED) == 8'h00)
        else $error("undefined configuration bits set");

    c_one_shot: cover property (@(posedge clk) disable iff (rst)
        standby && start_conv);
    c_queue_three: cover property (@(posedge clk) disable iff (rst)
        conv_done && device_configuration[0] && remote_hit[2]);
    c_alert_clear: cover property (@(posedge clk) disable iff (rst)
        alert_output ##1 rd_status ##[1:20] !alert_output);

endmodule : temp_sensor_conversion_control

// [host_model.sv]
// Host model issuing command-byte register accesses to the sensor.
// Assumes the bench calls wr and rd; requests change at the falling edge.
`timescale 1ns/10ps
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic      [7:0] cmd_code,
    output logic            wr_req,
    output logic      [7:0] wr_data,
    output logic            rd_req
);
    // ====================
    // Access tasks
    initial
    begin
        cmd_code = 8'h00;
        wr_data  = 8'h00;
        wr_req   = 1'b0;
        rd_req   = 1'b0;
    end
    // Idle lines show inverted values so stale data never looks live
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(negedge clk);
        cmd_code <= c;
        wr_data  <= d;
        wr_req   <= 1'b1;
        @(negedge clk);
        wr_req   <= 1'b0;
        cmd_code <= ~c;
        wr_data  <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [7:0] r);
        @(negedge clk);
        cmd_code <= c;
        rd_req   <= 1'b1;
        @(negedge clk);
        r = (rd_valid === 1'b1) ? rd_data : 8'hXX;
        rd_req   <= 1'b0;
        cmd_code <= ~c;
    endtask : rd
endmodule : host_model

// [temp_sensor_conversion_control_tb_top.sv]
// Bench for the conversion controller: register sequences and event checks.
// Assumes host_model drives the register port; samples are set here.
`timescale 1ns/10ps
module temp_sensor_conversion_control_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cmd_code, wr_data, rd_data, r;
    logic        wr_req, rd_req, rd_valid, alert_output, critical_output, converting;
    logic        diode_open = 1'b0;
    logic [10:0] local_sample = 11'h000;
    logic [10:0] remote_sample = 11'h000;
    logic [15:0] cnt;
    logic [19:0] tbl [7];
    int          fail_count = 0;
    int          n_checks = 0;
    int          k;
    // ====================
    // Rows: config, status, {open, alert, critical}
    initial tbl = '{20'h41413, 20'h41413, 20'h41533, 20'h44533, 20'h50533, 20'h54532, 20'hD4574};
    always #50 clk = ~clk;
    host_model u_host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_code(cmd_code), .wr_req(wr_req), .wr_data(wr_data), .rd_req(rd_req));
    // Short counts keep the run brief; slowest free-run gap becomes 4096 cycles
    temp_sensor_conversion_control #(.CONV_CYCLES(20), .SLOW_CYCLES(28'h0001000)) u_dut (
        .clk(clk), .rst(rst), .cmd_code(cmd_code), .wr_req(wr_req), .wr_data(wr_data),
        .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .local_sample(local_sample), .remote_sample(remote_sample), .diode_open(diode_open),
        .alert_output(alert_output), .critical_output(critical_output),
        .converting(converting));
    // ====================
    // Helpers
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input string n, input logic [7:0] c, input logic [7:0] e);
        u_host.rd(c, r);
        chk(n, r, e);
    endtask : rchk
    // Bounded waits, so a stuck converter shows up as mismatches
    task automatic conv;
        for (k = 0; k < 50 && converting !== 1'b1; k++) @(negedge clk);
        for (k = 0; k < 100 && converting !== 1'b0; k++) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask : conv
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // ====================
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // ====================
    // Tests
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        u_host.wr(8'h0D, 8'h60);
        chk("busy", {7'h00, converting}, 8'h01);
        rchk("config", 8'h03, 8'h00);
        rchk("rate", 8'h04, 8'h08);
        rchk("lhigh_rst", 8'h05, 8'h46);
        rchk("remote_critical_flag_rst", 8'h19, 8'h55);
        rchk("local_critical_flag_rst", 8'h20, 8'h55);
        rchk("one_shot", 8'h0F, 8'hFF);
        u_host.wr(8'h09, 8'hFF);
        rchk("config_ff", 8'h03, 8'hD5);
        u_host.wr(8'h09, 8'h40);
        u_host.wr(8'h00, 8'hFF);
        conv();
        rchk("status", 8'h02, 8'h00);
        rchk("local_hb", 8'h00, 8'h00);
        repeat (40) @(negedge clk);
        chk("standby", {7'h00, converting}, 8'h00);
        rchk("remote_high", 8'h07, 8'h60);
        $display("test reset done");
        local_sample = 11'h2B3;
        remote_sample = 11'h305;
        for (int j = 0; j < 7; j++)
        begin
            diode_open = tbl[j][2];
            u_host.wr(8'h09, tbl[j][19:12]);
            u_host.wr(8'h0F, 8'h5A);
            conv();
            chk("alert", {7'h00, alert_output}, {7'h00, tbl[j][1]});
            chk("crit", {7'h00, critical_output}, {7'h00, tbl[j][0]});
            rchk("flags", 8'h02, tbl[j][11:4]);
        end
        // Low limits above the readings, remote high limit nudged just above by its low byte
        u_host.wr(8'h0C, 8'h60);
        u_host.wr(8'h0E, 8'h70);
        u_host.wr(8'h13, 8'hC0);
        u_host.wr(8'h0F, 8'h00);
        conv();
        rchk("lows", 8'h02, 8'h6F);
        rchk("rhigh_lb", 8'h13, 8'hC0);
        repeat (40) @(negedge clk);
        chk("single", {7'h00, converting}, 8'h00);
        rchk("local_hb", 8'h00, 8'h56);
        rchk("remote_hb", 8'h01, 8'h60);
        rchk("remote_lb", 8'h10, 8'hA0);
        rchk("local_lb", 8'h22, 8'h60);
        $display("test events done");
        u_host.wr(8'h0A, 8'h00);
        u_host.wr(8'h09, 8'h00);
        rchk("rate0", 8'h04, 8'h00);
        // Measured fall to fall, so the span equals one start-to-start interval
        for (k = 0; k < 50 && converting !== 1'b0; k++) @(negedge clk);
        cnt = 16'h0000;
        for (; converting !== 1'b1 && cnt < 16'h1400; cnt++) @(negedge clk);
        for (; converting === 1'b1 && cnt < 16'h1400; cnt++) @(negedge clk);
        chk("gap_hi", cnt[15:8], 8'h10);
        chk("gap_lo", cnt[7:0], 8'h00);
        $display("test freerun done");
        report_and_stop();
    end
endmodule : temp_sensor_conversion_control_tb_top
